// ---- src/nfc_defines.svh ----
`ifndef NFC_DEFINES_SVH
`define NFC_DEFINES_SVH

// ****************************************
// Controller register offsets
// ****************************************
`define NFC_REG_CTRL 8'h00
`define NFC_REG_ADDR 8'h04
`define NFC_REG_WDATA 8'h08
`define NFC_REG_STATUS 8'h0C
`define NFC_REG_RDATA 8'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define NFC_CTRL_OP_LSB 0
`define NFC_CTRL_OP_MSB 3
`define NFC_CTRL_NOPOLL 4
`define NFC_STAT_BUSY 0
`define NFC_STAT_DONE 1
`define NFC_STAT_FAIL 2
`define NFC_STAT_WINDOW 3
`define NFC_STAT_IDENT 4
`define NFC_ADDR_W 19
`define NFC_RST_ADDR 19'h00000
`define NFC_RST_BYTE 8'h00

// ****************************************
// Flash command set
// ****************************************
`define NFC_UNLOCK1_ADDR 19'h00555
`define NFC_UNLOCK2_ADDR 19'h002AA
`define NFC_UNLOCK1_DATA 8'hAA
`define NFC_UNLOCK2_DATA 8'h55
`define NFC_CMD_RESET 8'hF0
`define NFC_CMD_IDENT 8'h90
`define NFC_CMD_PROG 8'hA0
`define NFC_CMD_ERASE 8'h80
`define NFC_CMD_CHIP 8'h10
`define NFC_CMD_SECTOR 8'h30
`define NFC_CMD_SUSPEND 8'hB0
`define NFC_CMD_RESUME 8'h30
`define NFC_SECTOR_MSB 18
`define NFC_SECTOR_LSB 16

// ****************************************
// Status bit positions on the data pins
// ****************************************
`define NFC_POLL_BIT 7
`define NFC_TOGGLE1_BIT 6
`define NFC_FAIL_BIT 5
`define NFC_WINDOW_BIT 3

// ****************************************
// Pin timing
// ****************************************
`define NFC_CLK_PERIOD_NS 4
`define NFC_T_PULSE_NS 40
`define NFC_PULSE_CYC ((`NFC_T_PULSE_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS)

`endif

// ---- src/nfc_pkg.sv ----
`include "nfc_defines.svh"

package nfc_pkg;

  // Operations that software may start; OP_NONE starts nothing
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_RESET = 4'h1,
    OP_IDENT = 4'h2,
    OP_PROG = 4'h3,
    OP_CHIP = 4'h4,
    OP_SECT = 4'h5,
    OP_SECT_ADD = 4'h6,
    OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8,
    OP_READ = 4'h9
  } nfc_op_t;

  // Controller sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WRITE = 5'h02,
    ST_READ = 5'h04,
    ST_POLL = 5'h08,
    ST_FINAL = 5'h10
  } nfc_state_t;

  // Bus cycle phases
  typedef enum logic [3:0] {
    CY_IDLE = 4'h1,
    CY_SETUP = 4'h2,
    CY_STROBE = 4'h4,
    CY_HOLD = 4'h8
  } nfc_cyc_t;

  // One flash bus cycle
  typedef struct packed {
    logic write;
    logic [`NFC_ADDR_W-1:0] addr;
    logic [7:0] data;
  } nfc_cyc_req_t;

  // Flash pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [`NFC_ADDR_W-1:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } nfc_pins_t;

endpackage

// ---- src/nfc_seq_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defines.svh"

module nfc_seq_rom (
  // Operation and position in its sequence
  input wire nfc_pkg::nfc_op_t op,
  input wire logic [2:0] step,
  input wire logic [`NFC_ADDR_W-1:0] addr,
  input wire logic [7:0] data,
  // Write cycle for this step
  output nfc_pkg::nfc_cyc_req_t req,
  output logic [2:0] n_writes
);

  logic [`NFC_ADDR_W-1:0] sector;

  // Sector address keeps only the sector select bits
  assign sector = {addr[`NFC_SECTOR_MSB:`NFC_SECTOR_LSB], 16'h0000};

  // Unlock addresses carry zeros above bit 10; the flash ignores them anyway
  always_comb begin
    req = '0;
    req.write = 1'b1;
    n_writes = 3'h0;
    case (op)
      nfc_pkg::OP_RESET: begin
        n_writes = 3'h1;
        req.data = `NFC_CMD_RESET;
      end
      nfc_pkg::OP_SUSPEND: begin
        n_writes = 3'h1;
        req.data = `NFC_CMD_SUSPEND;
      end
      nfc_pkg::OP_RESUME: begin
        n_writes = 3'h1;
        req.data = `NFC_CMD_RESUME;
      end
      nfc_pkg::OP_SECT_ADD: begin
        n_writes = 3'h1;
        req.addr = sector;
        req.data = `NFC_CMD_SECTOR;
      end
      nfc_pkg::OP_IDENT, nfc_pkg::OP_PROG, nfc_pkg::OP_CHIP, nfc_pkg::OP_SECT: begin
        n_writes = (op == nfc_pkg::OP_IDENT) ? 3'h3 : (op == nfc_pkg::OP_PROG) ? 3'h4 : 3'h6;
        if (op == nfc_pkg::OP_PROG && step == 3'h3) begin
          req.addr = addr;
          req.data = data;
        end else begin
          case (step)
            3'h0, 3'h3: begin
              req.addr = `NFC_UNLOCK1_ADDR;
              req.data = `NFC_UNLOCK1_DATA;
            end
            3'h1, 3'h4: begin
              req.addr = `NFC_UNLOCK2_ADDR;
              req.data = `NFC_UNLOCK2_DATA;
            end
            3'h2: begin
              req.addr = `NFC_UNLOCK1_ADDR;
              req.data = (op == nfc_pkg::OP_IDENT) ? `NFC_CMD_IDENT :
                         (op == nfc_pkg::OP_PROG) ? `NFC_CMD_PROG : `NFC_CMD_ERASE;
            end
            default: begin
              req.addr = (op == nfc_pkg::OP_CHIP) ? `NFC_UNLOCK1_ADDR : sector;
              req.data = (op == nfc_pkg::OP_CHIP) ? `NFC_CMD_CHIP : `NFC_CMD_SECTOR;
            end
          endcase
        end
      end
      default: begin
        n_writes = 3'h0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- src/nfc_bus_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defines.svh"

module nfc_bus_cycle #(
  parameter int unsigned PULSE_CYC = `NFC_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Cycle request
  input wire logic req_valid,
  input wire nfc_pkg::nfc_cyc_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_byte,
  // Flash pins
  output nfc_pkg::nfc_pins_t pins,
  input wire logic [7:0] dq_in
);

  nfc_pkg::nfc_cyc_t state;
  logic [7:0] cnt;
  logic is_write;

  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
    $error("PULSE_CYC must lie in 1..255");
  end

  assign req_ready = (state == nfc_pkg::CY_IDLE);

  // Phase sequencer: setup, strobe low, hold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= nfc_pkg::CY_IDLE;
      cnt <= 8'h00;
    end else if (clk_en) begin
      case (state)
        nfc_pkg::CY_IDLE: if (req_valid) state <= nfc_pkg::CY_SETUP;
        nfc_pkg::CY_SETUP: begin
          state <= nfc_pkg::CY_STROBE;
          cnt <= 8'(PULSE_CYC - 1);
        end
        nfc_pkg::CY_STROBE: begin
          if (cnt == 8'h00) state <= nfc_pkg::CY_HOLD;
          else cnt <= cnt - 8'h01;
        end
        default: state <= nfc_pkg::CY_IDLE;
      endcase
    end
  end

  // Pins: address and data settle before the strobe falls, stay past its rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins.ce_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.oe_n <= 1'b1;
      pins.addr <= `NFC_RST_ADDR;
      pins.dq_out <= `NFC_RST_BYTE;
      pins.dq_oe <= 1'b0;
      is_write <= 1'b0;
    end else if (clk_en) begin
      case (state)
        nfc_pkg::CY_IDLE: begin
          if (req_valid) begin
            pins.ce_n <= 1'b0;
            pins.addr <= req.addr;
            pins.dq_out <= req.data;
            pins.dq_oe <= req.write;
            is_write <= req.write;
          end
        end
        nfc_pkg::CY_SETUP: begin
          pins.we_n <= !is_write;
          pins.oe_n <= is_write;
        end
        nfc_pkg::CY_STROBE: begin
          if (cnt == 8'h00) begin
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
          end
        end
        default: begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 1'b0;
        end
      endcase
    end
  end

  // Read byte is taken at the end of the output strobe; done marks cycle end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_byte <= 8'h00;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= (state == nfc_pkg::CY_HOLD);
      if (state == nfc_pkg::CY_STROBE && cnt == 8'h00 && !is_write) rd_byte <= dq_in;
    end
  end

  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (sys_rst);

  strobe_excl_a: assert property (!(!pins.we_n && !pins.oe_n))
    else $error("write and output strobes low together");
  no_contend_a: assert property (pins.dq_oe |-> pins.oe_n)
    else $error("data driven while flash output is on");
  addr_setup_a: assert property ($fell(pins.we_n) |-> $stable(pins.addr) && $past(!pins.ce_n))
    else $error("address not settled before write strobe fell");
  data_hold_a: assert property ($rose(pins.we_n) |-> pins.dq_oe && !pins.ce_n ##1 $stable(pins.dq_out))
    else $error("data not held across write strobe rise");

endmodule

`default_nettype wire

// ---- src/nfc_ctrl.sv ----
// Notes on behaviour
// - Write F0 anywhere returns flash to array.
// - Identify: AA/555, 55/2AA, 90/555, then read.
// - Program: three command writes, then target byte.
// - Erase: six writes; chip 10, sector 30.
// - Poll at program location or erasing sector.
// - Take valid data only on later read.
// - Recheck status after timeout fail bit seen.
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defines.svh"

module nfc_ctrl #(
  parameter int unsigned PULSE_CYC = `NFC_PULSE_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins
  output nfc_pkg::nfc_pins_t flash_pins,
  input wire logic [7:0] flash_dq_in
);

  // ****************************************
  // Declarations
  // ****************************************
  nfc_pkg::nfc_state_t state;
  nfc_pkg::nfc_op_t op_reg;
  nfc_pkg::nfc_op_t new_op;
  nfc_pkg::nfc_cyc_req_t rom_req;
  nfc_pkg::nfc_cyc_req_t cyc_req;
  logic [`NFC_ADDR_W-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [7:0] prev_byte;
  logic [7:0] rd_byte;
  logic [2:0] step;
  logic [2:0] n_writes;
  logic no_poll;
  logic have_prev;
  logic fail_seen;
  logic done_flag;
  logic fail_flag;
  logic window_flag;
  logic ident_mode;
  logic cyc_valid;
  logic cyc_ready;
  logic cyc_done;
  logic start;
  logic wr_last;
  logic wr_poll;
  logic finish;
  logic toggling;
  logic poll_over;
  logic poll_fail;
  logic [31:0] status_word;

  // ****************************************
  // Command decode and handshakes
  // ****************************************

  // Unknown operation codes and starts while busy are dropped
  assign new_op = nfc_pkg::nfc_op_t'(reg_wdata[`NFC_CTRL_OP_MSB:`NFC_CTRL_OP_LSB]);
  assign start = reg_wr && reg_addr == `NFC_REG_CTRL && state == nfc_pkg::ST_IDLE
                 && new_op != nfc_pkg::OP_NONE && new_op <= nfc_pkg::OP_READ;

  // Last write of a sequence and what follows it
  assign wr_last = state == nfc_pkg::ST_WRITE && cyc_done && step == 3'(n_writes - 3'h1);
  assign wr_poll = !no_poll && (op_reg == nfc_pkg::OP_PROG || op_reg == nfc_pkg::OP_CHIP
                   || op_reg == nfc_pkg::OP_SECT || op_reg == nfc_pkg::OP_SECT_ADD
                   || op_reg == nfc_pkg::OP_SUSPEND);
  assign finish = (wr_last && !wr_poll && op_reg != nfc_pkg::OP_IDENT)
                  || (cyc_done && (state == nfc_pkg::ST_READ || state == nfc_pkg::ST_FINAL));

  // Two reads that agree in toggle bit one mean the flash is no longer busy
  assign toggling = prev_byte[`NFC_TOGGLE1_BIT] != rd_byte[`NFC_TOGGLE1_BIT];
  assign poll_over = state == nfc_pkg::ST_POLL && cyc_done && have_prev && !toggling;
  assign poll_fail = state == nfc_pkg::ST_POLL && cyc_done && have_prev && toggling
                     && fail_seen;

  // A new request waits one cycle after done so no cycle is issued twice
  assign cyc_valid = state != nfc_pkg::ST_IDLE && !cyc_done;

  // Writes come from the sequence table, reads always go to the held address
  always_comb begin
    cyc_req = rom_req;
    if (state != nfc_pkg::ST_WRITE) begin
      cyc_req.write = 1'b0;
      cyc_req.addr = addr_reg;
      cyc_req.data = 8'h00;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************

  // Main state: write sequence, then read, poll or finish
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= nfc_pkg::ST_IDLE;
    end else if (clk_en) begin
      case (state)
        nfc_pkg::ST_IDLE: begin
          if (start) begin
            state <= (new_op == nfc_pkg::OP_READ) ? nfc_pkg::ST_READ : nfc_pkg::ST_WRITE;
          end
        end
        nfc_pkg::ST_WRITE: begin
          if (finish) state <= nfc_pkg::ST_IDLE;
          else if (wr_last && op_reg == nfc_pkg::OP_IDENT) state <= nfc_pkg::ST_READ;
          else if (wr_last) state <= nfc_pkg::ST_POLL;
        end
        nfc_pkg::ST_POLL: begin
          if (poll_over) state <= nfc_pkg::ST_FINAL;
          else if (poll_fail) state <= nfc_pkg::ST_WRITE;
        end
        default: begin
          if (finish) state <= nfc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Operation and step; a failed operation turns into a reset write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= nfc_pkg::OP_NONE;
      no_poll <= 1'b0;
      step <= 3'h0;
    end else if (clk_en) begin
      if (start) begin
        op_reg <= new_op;
        no_poll <= reg_wdata[`NFC_CTRL_NOPOLL];
        step <= 3'h0;
      end else if (poll_fail) begin
        op_reg <= nfc_pkg::OP_RESET;
        step <= 3'h0;
      end else if (state == nfc_pkg::ST_WRITE && cyc_done) begin
        step <= step + 3'h1;
      end
    end
  end

  // Poll history; fail bit while toggling earns one more read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      have_prev <= 1'b0;
      fail_seen <= 1'b0;
      prev_byte <= 8'h00;
    end else if (clk_en) begin
      if (start) begin
        have_prev <= 1'b0;
        fail_seen <= 1'b0;
      end else if (state == nfc_pkg::ST_POLL && cyc_done) begin
        have_prev <= 1'b1;
        prev_byte <= rd_byte;
        if (have_prev && toggling && rd_byte[`NFC_FAIL_BIT]) fail_seen <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status flags and software registers
  // ****************************************

  // Done and fail flags are sticky, cleared only by the next start, which cannot meet a finish; ident_mode clears when a reset finishes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      window_flag <= 1'b0;
      ident_mode <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      if (finish) done_flag <= 1'b1;
      else if (start) done_flag <= 1'b0;
      if (poll_fail) fail_flag <= 1'b1;
      else if (start) fail_flag <= 1'b0;
      if (state == nfc_pkg::ST_POLL && cyc_done) window_flag <= rd_byte[`NFC_WINDOW_BIT];
      else if (start) window_flag <= 1'b0;
      if (wr_last && op_reg == nfc_pkg::OP_IDENT) ident_mode <= 1'b1;
      else if (finish && op_reg == nfc_pkg::OP_RESET) ident_mode <= 1'b0;
      if (cyc_done && state != nfc_pkg::ST_WRITE) rdata_reg <= rd_byte;
    end
  end

  // Address and program byte; held fixed while an operation runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= `NFC_RST_ADDR;
      wdata_reg <= `NFC_RST_BYTE;
    end else if (clk_en && reg_wr && state == nfc_pkg::ST_IDLE) begin
      if (reg_addr == `NFC_REG_ADDR) addr_reg <= reg_wdata[`NFC_ADDR_W-1:0];
      else if (reg_addr == `NFC_REG_WDATA) wdata_reg <= reg_wdata[7:0];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`NFC_STAT_BUSY] = state != nfc_pkg::ST_IDLE;
    status_word[`NFC_STAT_DONE] = done_flag;
    status_word[`NFC_STAT_FAIL] = fail_flag;
    status_word[`NFC_STAT_WINDOW] = window_flag;
    status_word[`NFC_STAT_IDENT] = ident_mode;
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!reg_rd) reg_rdata <= 32'h0000_0000;
      else if (reg_addr == `NFC_REG_CTRL) reg_rdata <= {27'h0, no_poll, op_reg};
      else if (reg_addr == `NFC_REG_ADDR) reg_rdata <= {13'h0, addr_reg};
      else if (reg_addr == `NFC_REG_WDATA) reg_rdata <= {24'h0, wdata_reg};
      else if (reg_addr == `NFC_REG_STATUS) reg_rdata <= status_word;
      else if (reg_addr == `NFC_REG_RDATA) reg_rdata <= {24'h0, rdata_reg};
      else reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Submodules
  // ****************************************
  nfc_seq_rom u_rom (
    .op(op_reg),
    .step(step),
    .addr(addr_reg),
    .data(wdata_reg),
    .req(rom_req),
    .n_writes(n_writes)
  );

  nfc_bus_cycle #(
    .PULSE_CYC(PULSE_CYC)
  ) u_cyc (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req_valid(cyc_valid),
    .req(cyc_req),
    .req_ready(cyc_ready),
    .done(cyc_done),
    .rd_byte(rd_byte),
    .pins(flash_pins),
    .dq_in(flash_dq_in)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (sys_rst);

  unlock_first_a: assert property (state == nfc_pkg::ST_WRITE && cyc_valid && cyc_ready
      && step == 3'h0 && op_reg == nfc_pkg::OP_PROG
      |-> cyc_req.addr == `NFC_UNLOCK1_ADDR && cyc_req.data == `NFC_UNLOCK1_DATA)
    else $error("program sequence did not open with unlock write");
  erase_last_a: assert property (state == nfc_pkg::ST_WRITE && step == 3'h5
      && op_reg == nfc_pkg::OP_CHIP |-> cyc_req.data == `NFC_CMD_CHIP)
    else $error("chip erase sequence ended with wrong command");
  reset_on_fail_a: assert property ($rose(fail_flag)
      |-> state == nfc_pkg::ST_WRITE && op_reg == nfc_pkg::OP_RESET && step == 3'h0)
    else $error("failure not followed by reset write");
  fail_recheck_a: assert property ($rose(fail_flag) |-> $past(fail_seen))
    else $error("failure declared without recheck");
  poll_addr_a: assert property (state == nfc_pkg::ST_POLL && cyc_valid
      |-> cyc_req.addr == addr_reg && !cyc_req.write)
    else $error("poll read not at held address");
  final_read_a: assert property (state == nfc_pkg::ST_POLL |=> state != nfc_pkg::ST_IDLE)
    else $error("poll finished without a final read");
  start_busy_a: assert property (start |=> status_word[`NFC_STAT_BUSY] && !done_flag)
    else $error("accepted start did not show busy");
  rd_status_a: assert property (reg_rd && reg_addr == `NFC_REG_STATUS
      |=> reg_rdata == $past(status_word))
    else $error("status read returned wrong word");

  prog_done_c: cover property (poll_over && op_reg == nfc_pkg::OP_PROG ##[1:40] finish);
  fail_path_c: cover property (poll_fail ##[1:40] finish);
  ident_read_c: cover property (state == nfc_pkg::ST_READ && op_reg == nfc_pkg::OP_IDENT
      && cyc_done);
  suspend_c: cover property (poll_over && op_reg == nfc_pkg::OP_SUSPEND);

endmodule

`default_nettype wire

// ---- tb/nfc_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART = 8'hC3, // Arbitrary value
  parameter logic [7:0] LOCK = 8'h80,
  parameter int BUSY_NS = 2000
) (
  // Pins
  input wire nfc_pkg::nfc_pins_t pins,
  output logic [7:0] dq
);
  logic [7:0] mem [256];
  logic [7:0] pv, d, val, last;
  logic [10:0] a;
  logic [2:0] st;
  logic ident, busy, erase, tog, stuck;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {st, ident, busy, erase, tog, stuck, pv, last} = '0;
  end
  // Busy span; a stuck program waits for F0
  task automatic start(input logic er);
    busy = 1'b1;
    erase = er;
    if (!stuck) fork
      #BUSY_NS busy = 1'b0;
    join_none
  endtask
  // ****
  // Command decoder
  // ****
  always @(posedge pins.we_n) begin
    a = pins.addr[10:0];
    d = pins.dq_out; // Taken as the strobe rises
    if (pins.ce_n || (busy && !stuck)) begin // Commands ignored while busy, unless the program is stuck
    end else if (d == 8'hF0) begin
      {st, ident, stuck, busy} = '0;
    end else begin
      case (st)
        3'd0, 3'd4: st = (a == 11'h555 && d == 8'hAA) ? st + 3'd1 : 3'd0;
        3'd1, 3'd5: st = (a == 11'h2AA && d == 8'h55) ? st + 3'd1 : 3'd0;
        3'd2: begin
          ident = a == 11'h555 && d == 8'h90;
          st = a != 11'h555 ? 3'd0 : d == 8'hA0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
        end
        3'd3: begin
          pv = d;
          stuck = pins.addr[7:0] == 8'hEE;
          if (!LOCK[pins.addr[18:16]] && !stuck) mem[pins.addr[7:0]] = d;
          start(1'b0);
          st = 3'd0;
        end
        default: begin
          if (d == 8'h10 || d == 8'h30) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            start(1'b1);
          end
          st = 3'd0;
        end
      endcase
    end
  end
  // Read value: identity, status or array
  always_comb begin
    if (ident) begin
      val = pins.addr[1:0] == 2'h0 ? MAKER : pins.addr[1:0] == 2'h1 ? PART :
        {7'h00, LOCK[pins.addr[18:16]]};
    end else if (busy) begin
      val = {erase ? 1'b0 : ~pv[7], tog, stuck, 1'b0, erase, erase & tog, 2'h0};
      // Erase shows its window closed and toggle bit two flipping
    end else begin
      val = mem[pins.addr[7:0]];
    end
  end
  // Toggle per read; released pins show the inverse of the last byte
  always @(posedge pins.oe_n) begin
    last = val;
    if (busy) tog = ~tog;
  end
  assign dq = pins.oe_n ? ~last : val;
endmodule
`default_nettype wire

// ---- tb/nor_flash_command_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nfc_defines.svh"
module nor_flash_command_status_tb;
  typedef struct packed {logic [3:0] op; logic [18:0] a; logic [7:0] e;} nfc_row_t;
  logic clk, sys_rst, reg_wr, reg_rd;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr, flash_dq_in;
  logic [31:0] reg_wdata, reg_rdata, s;
  nfc_pkg::nfc_pins_t flash_pins;
  int n_fail = 0;
  int compares = 0;
  nfc_row_t rows [15] = '{'{4'h3, 19'h00012, 8'h5A}, '{4'h9, 19'h00012, 8'h5A},
    '{4'h2, 19'h00000, 8'h3C}, '{4'h2, 19'h00001, 8'hC3}, '{4'h2, 19'h70002, 8'h01},
    '{4'h2, 19'h00002, 8'h00}, '{4'h1, 19'h00000, 8'h00}, '{4'h9, 19'h00012, 8'h5A},
    '{4'h3, 19'h70010, 8'hFF}, '{4'h9, 19'h70010, 8'hFF}, '{4'h4, 19'h00012, 8'hFF},
    '{4'h9, 19'h00012, 8'hFF}, '{4'h5, 19'h00012, 8'hFF}, '{4'h7, 19'h00012, 8'hFF},
    '{4'h8, 19'h00012, 8'hFF}};
  nfc_ctrl #(.PULSE_CYC(1)) u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
  nfc_flash_model u_flash (.pins(flash_pins), .dq(flash_dq_in));
  // ****
  // Bus tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Start one operation and wait, bounded, for busy to drop
  task automatic op(input logic [3:0] o, input logic [18:0] a);
    wr(`NFC_REG_ADDR, {13'h0000, a});
    wr(`NFC_REG_WDATA, {24'h000000, a[7:0] ^ 8'h48});
    wr(`NFC_REG_CTRL, {28'h0000000, o});
    s = 32'h1;
    for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) rd(`NFC_REG_STATUS, s);
  endtask
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog, well beyond the few busy spans of the run
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
    repeat (5) @(posedge clk);
    check({flash_pins.ce_n, flash_pins.we_n, flash_pins.oe_n, flash_pins.dq_oe}, 4'hE);
    sys_rst <= 1'b0;
    // Program data is WDATA = address low byte ^ 48
    rows[0].e = 8'h12 ^ 8'h48;
    rows[1].e = rows[0].e;
    rows[7].e = rows[0].e;
    for (int i = 0; i < 15; i++) begin
      op(rows[i].op, rows[i].a);
      rd(`NFC_REG_RDATA, s);
      if (rows[i].op != 4'h1) check(s, {24'h0, rows[i].e});
      $display("row %0d done", i);
    end
    // Program that never finishes: fail flagged, reset written
    op(4'h3, 19'h000EE);
    check(s[2:0], 3'h6);
    op(4'h9, 19'h00012);
    rd(`NFC_REG_RDATA, s);
    check(s, 32'hFF);
    $display("fail test done");
    rd(8'h20, s);
    check(s, 32'h0);
    // A start given while the enable is low must not be taken
    @(posedge clk);
    clk_en <= 1'b0;
    wr(`NFC_REG_CTRL, 32'h9);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(`NFC_REG_STATUS, s);
    check(s[0], 1'b0);
    $display("enable test done");
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1 check({flash_pins.ce_n, flash_pins.we_n, flash_pins.oe_n, flash_pins.dq_oe}, 4'hE);
    $display("reset test done");
    test_done();
  end
endmodule
`default_nettype wire
